// File: inc/ref_pkg.sv
// shared constants and carriers for the radio event flag bank
package ref_pkg;
   // ****************
   // sizes
   // ****************
   localparam int NUM_EVT = 13;
   localparam int BC_W = 16;

   // ****************
   // event indices
   // ****************
   localparam int IDX_RSSI = 0;
   localparam int IDX_BCM = 1;
   localparam int IDX_CRC_GOOD = 2;
   localparam int IDX_CRC_BAD = 3;
   localparam int IDX_FRAME = 4;
   localparam int IDX_ED_DONE = 5;
   localparam int IDX_ED_HALT = 6;
   localparam int IDX_CLEAR = 7;
   localparam int IDX_BUSY = 8;
   localparam int IDX_ASSESS = 9;
   localparam int IDX_RATE = 10;
   localparam int IDX_TX = 11;
   localparam int IDX_RX = 12;

   // ****************
   // register offsets
   // ****************
   localparam logic [11:0] EVT_OFS [NUM_EVT] = '{
      12'h11C, 12'h128, 12'h130, 12'h134, 12'h138, 12'h13C, 12'h140,
      12'h144, 12'h148, 12'h14C, 12'h150, 12'h154, 12'h158};
   localparam logic [11:0] OFS_INT_STATUS = 12'h400;
   localparam logic [11:0] OFS_INT_MASK = 12'h404;
   localparam logic [11:0] OFS_RX_MODE = 12'h408;
   localparam logic [11:0] OFS_BC_COMPARE = 12'h40C;
   localparam logic [11:0] OFS_BC_COUNT = 12'h410;

   // ****************
   // reset values
   // ****************
   localparam logic [NUM_EVT-1:0] RST_EVT = 13'h0000;
   localparam logic [NUM_EVT-1:0] RST_MASK = 13'h0000;
   localparam logic RST_RX_MODE = 1'b0;
   localparam logic [BC_W-1:0] RST_BC_COMPARE = 16'h0000;

   // ****************
   // bus answers
   // ****************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // one-cycle event strobes from the radio core
   typedef struct packed {
      logic rx_path_ready;
      logic tx_path_ready;
      logic rate_upshift;
      logic assess_halted;
      logic chan_occupied;
      logic chan_clear;
      logic ed_halted;
      logic ed_done;
      logic frame_len_seen;
      logic crc_bad;
      logic crc_good;
      logic rssi_done;
   } ref_radio_evt_s;

   // on-air bit counter control
   typedef struct packed {
      logic run;
      logic tick;
   } ref_bitcnt_s;
endpackage

// File: logic/ref_event_bank.sv
// radio event flag bank with AXI4-Lite register access
//
// The AXI4-Lite slave port was chosen for this implementation.
module ref_event_bank
   import ref_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input ref_radio_evt_s radio_evt,
   input ref_bitcnt_s bit_cnt,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq,
   output logic rx_long_range_fast
);
   // ****************
   // write channel
   // ****************
   logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt, bvalid_r, bvalid_nxt, wr_en;
   logic [11:0] aw_addr_r, aw_addr_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0] w_strb_r, w_strb_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic [31:0] be;
   logic [NUM_EVT-1:0] wr_evt;
   logic wr_st, wr_mask, wr_mode, wr_cmp;
   assign s_axi_awready = !aw_held_r;
   assign s_axi_wready = !w_held_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign wr_en = aw_held_r && w_held_r && !bvalid_r;
   assign be = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

   always_comb begin
      wr_st = 1'b0;
      wr_mask = 1'b0;
      wr_mode = 1'b0;
      wr_cmp = 1'b0;
      for (int k = 0; k < NUM_EVT; k++) begin
         wr_evt[k] = wr_en && w_strb_r[0] && (aw_addr_r[11:2] == EVT_OFS[k][11:2]);
      end
      if (aw_addr_r[11:2] == OFS_INT_STATUS[11:2]) begin
         wr_st = wr_en;
      end else if (aw_addr_r[11:2] == OFS_INT_MASK[11:2]) begin
         wr_mask = wr_en;
      end else if (aw_addr_r[11:2] == OFS_RX_MODE[11:2]) begin
         wr_mode = wr_en && w_strb_r[0];
      end else if (aw_addr_r[11:2] == OFS_BC_COMPARE[11:2]) begin
         wr_cmp = wr_en;
      end
   end

   always_comb begin
      aw_held_nxt = aw_held_r;
      aw_addr_nxt = aw_addr_r;
      w_held_nxt = w_held_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      if (s_axi_awvalid && !aw_held_r) begin
         aw_held_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_r) begin
         w_held_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_en) begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         // the count register is read-only, so it answers like a hole
         bresp_nxt = (|wr_evt || wr_st || wr_mask || wr_cmp ||
                      (aw_addr_r[11:2] == OFS_RX_MODE[11:2])) ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 12'h000;
         w_held_r <= 1'b0;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else begin
         aw_held_r <= aw_held_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_held_r <= w_held_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   // ****************
   // bit counter
   // ****************
   logic [BC_W-1:0] cnt_r, cnt_nxt, cmp_r, cmp_nxt, cnt_inc;
   logic bc_match;
   assign cnt_inc = cnt_r + 16'h0001;
   assign bc_match = bit_cnt.run && bit_cnt.tick && (cnt_inc == cmp_r);

   always_comb begin
      cnt_nxt = cnt_r;
      cmp_nxt = wr_cmp ? ((w_data_r[BC_W-1:0] & be[BC_W-1:0]) | (cmp_r & ~be[BC_W-1:0])) : cmp_r;
      // counter clears whenever the radio is not counting
      if (!bit_cnt.run) begin
         cnt_nxt = 16'h0000;
      end else if (bit_cnt.tick) begin
         cnt_nxt = cnt_inc;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         cnt_r <= 16'h0000;
         cmp_r <= RST_BC_COMPARE;
      end else begin
         cnt_r <= cnt_nxt;
         cmp_r <= cmp_nxt;
      end
   end

   // ****************
   // event flags
   // ****************
   logic [NUM_EVT-1:0] ev_pulse, evt_r, evt_nxt, st_r, st_nxt, mask_r, mask_nxt, st_clr;
   logic mode_r, mode_nxt, irq_r, irq_nxt;
   always_comb begin
      ev_pulse[IDX_RSSI] = radio_evt.rssi_done;
      ev_pulse[IDX_BCM] = bc_match;
      ev_pulse[IDX_CRC_GOOD] = radio_evt.crc_good;
      ev_pulse[IDX_CRC_BAD] = radio_evt.crc_bad;
      ev_pulse[IDX_FRAME] = radio_evt.frame_len_seen;
      ev_pulse[IDX_ED_DONE] = radio_evt.ed_done;
      ev_pulse[IDX_ED_HALT] = radio_evt.ed_halted;
      ev_pulse[IDX_CLEAR] = radio_evt.chan_clear;
      ev_pulse[IDX_BUSY] = radio_evt.chan_occupied;
      ev_pulse[IDX_ASSESS] = radio_evt.assess_halted;
      ev_pulse[IDX_RATE] = radio_evt.rate_upshift;
      ev_pulse[IDX_TX] = radio_evt.tx_path_ready;
      ev_pulse[IDX_RX] = radio_evt.rx_path_ready;
   end

   always_comb begin
      st_clr = wr_st ? (w_data_r[NUM_EVT-1:0] & be[NUM_EVT-1:0]) : 13'h0000;
      // a new event wins over a write in the same cycle
      for (int k = 0; k < NUM_EVT; k++) begin
         evt_nxt[k] = ev_pulse[k] | (wr_evt[k] ? w_data_r[0] : evt_r[k]);
      end
      st_nxt = ev_pulse | (st_r & ~st_clr);
      mask_nxt = wr_mask ? ((w_data_r[NUM_EVT-1:0] & be[NUM_EVT-1:0]) |
                            (mask_r & ~be[NUM_EVT-1:0])) : mask_r;
      mode_nxt = ev_pulse[IDX_RATE] | (wr_mode ? w_data_r[0] : mode_r);
      irq_nxt = |(st_nxt & mask_nxt);
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         evt_r <= RST_EVT;
         st_r <= RST_EVT;
         mask_r <= RST_MASK;
         mode_r <= RST_RX_MODE;
         irq_r <= 1'b0;
      end else begin
         evt_r <= evt_nxt;
         st_r <= st_nxt;
         mask_r <= mask_nxt;
         mode_r <= mode_nxt;
         irq_r <= irq_nxt;
      end
   end

   assign irq = irq_r;
   assign rx_long_range_fast = mode_r;

   // ****************
   // read channel
   // ****************
   logic rvalid_r, rvalid_nxt, rd_evt_r, rd_evt_nxt, rd_ok, rd_is_evt;
   logic [31:0] rdata_r, rdata_nxt, rd_word;
   logic [1:0] rresp_r, rresp_nxt;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   always_comb begin
      rd_word = 32'h00000000;
      rd_ok = 1'b0;
      rd_is_evt = 1'b0;
      for (int k = 0; k < NUM_EVT; k++) begin
         if (s_axi_araddr[11:2] == EVT_OFS[k][11:2]) begin
            rd_word = {31'h00000000, evt_r[k]};
            rd_ok = 1'b1;
            rd_is_evt = 1'b1;
         end
      end
      if (s_axi_araddr[11:2] == OFS_INT_STATUS[11:2]) begin
         rd_word = {19'h00000, st_r};
         rd_ok = 1'b1;
      end else if (s_axi_araddr[11:2] == OFS_INT_MASK[11:2]) begin
         rd_word = {19'h00000, mask_r};
         rd_ok = 1'b1;
      end else if (s_axi_araddr[11:2] == OFS_RX_MODE[11:2]) begin
         rd_word = {31'h00000000, mode_r};
         rd_ok = 1'b1;
      end else if (s_axi_araddr[11:2] == OFS_BC_COMPARE[11:2]) begin
         rd_word = {16'h0000, cmp_r};
         rd_ok = 1'b1;
      end else if (s_axi_araddr[11:2] == OFS_BC_COUNT[11:2]) begin
         rd_word = {16'h0000, cnt_r};
         rd_ok = 1'b1;
      end
   end

   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      rd_evt_nxt = rd_evt_r;
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && !rvalid_r) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_word;
         rresp_nxt = rd_ok ? RESP_OKAY : RESP_SLVERR;
         rd_evt_nxt = rd_is_evt;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= RESP_OKAY;
         rd_evt_r <= 1'b0;
      end else begin
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
         rd_evt_r <= rd_evt_nxt;
      end
   end

   // ****************
   // checks
   // ****************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   property p_rssi;
      radio_evt.rssi_done |=> evt_r[IDX_RSSI];
   endproperty
   a_rssi: assert property (p_rssi) else $error("rssi flag missed");
   property p_bcm;
      bit_cnt.run && bit_cnt.tick && (cnt_r + 16'h0001 == cmp_r) |=> evt_r[IDX_BCM];
   endproperty
   a_bcm: assert property (p_bcm) else $error("bit count match missed");
   property p_crc_good;
      radio_evt.crc_good |=> evt_r[IDX_CRC_GOOD] ##1
         (evt_r[IDX_CRC_GOOD] || $past(wr_evt[IDX_CRC_GOOD]));
   endproperty
   a_crc_good: assert property (p_crc_good) else $error("crc good flag missed");
   property p_crc_bad;
      radio_evt.crc_bad && !radio_evt.crc_good |=> evt_r[IDX_CRC_BAD] && !$rose(evt_r[IDX_CRC_GOOD]);
   endproperty
   a_crc_bad: assert property (p_crc_bad) else $error("crc bad flag wrong");
   property p_frame;
      radio_evt.frame_len_seen |=> evt_r[IDX_FRAME];
   endproperty
   a_frame: assert property (p_frame) else $error("frame flag missed");
   property p_ed_done;
      radio_evt.ed_done |=> evt_r[IDX_ED_DONE];
   endproperty
   a_ed_done: assert property (p_ed_done) else $error("energy done flag missed");
   property p_ed_halt;
      $rose(evt_r[IDX_ED_HALT]) |-> $past(radio_evt.ed_halted) || $past(wr_evt[IDX_ED_HALT]);
   endproperty
   a_ed_halt: assert property (p_ed_halt) else $error("energy halt flag spurious");
   property p_clear;
      radio_evt.chan_clear |=> evt_r[IDX_CLEAR];
   endproperty
   a_clear: assert property (p_clear) else $error("clear flag missed");
   property p_busy;
      radio_evt.chan_occupied |=> evt_r[IDX_BUSY];
   endproperty
   a_busy: assert property (p_busy) else $error("busy flag missed");
   property p_assess;
      radio_evt.assess_halted |=> evt_r[IDX_ASSESS];
   endproperty
   a_assess: assert property (p_assess) else $error("assessment halt flag missed");
   property p_rate;
      radio_evt.rate_upshift |=> evt_r[IDX_RATE] && rx_long_range_fast;
   endproperty
   a_rate: assert property (p_rate) else $error("rate upshift not applied");
   property p_tx;
      radio_evt.tx_path_ready |=> evt_r[IDX_TX];
   endproperty
   a_tx: assert property (p_tx) else $error("tx ready flag missed");
   property p_rx;
      radio_evt.rx_path_ready |=> evt_r[IDX_RX];
   endproperty
   a_rx: assert property (p_rx) else $error("rx ready flag missed");
   property p_rd_bit0;
      s_axi_rvalid && rd_evt_r |-> s_axi_rdata[31:1] == 31'h00000000;
   endproperty
   a_rd_bit0: assert property (p_rd_bit0) else $error("event word upper bits set");
   property p_sticky;
      evt_r[IDX_CRC_BAD] && !wr_evt[IDX_CRC_BAD] |=> evt_r[IDX_CRC_BAD];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped without write");
   property p_clear_wr;
      wr_evt[IDX_RX] && !w_data_r[0] && !radio_evt.rx_path_ready |=> !evt_r[IDX_RX];
   endproperty
   a_clear_wr: assert property (p_clear_wr) else $error("zero write did not clear");

   c_irq: cover property ($rose(irq));
   c_clear: cover property (wr_evt[IDX_CRC_GOOD] && !w_data_r[0] ##1 !evt_r[IDX_CRC_GOOD]);
   c_rate: cover property (radio_evt.rate_upshift ##1 rx_long_range_fast);
   c_bcm: cover property (bc_match);
endmodule

// File: tb/radio_event_flag_bank_tb.sv
// self-checking testbench for the radio event flag bank
module radio_event_flag_bank_tb
   import ref_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ****************
   // signals
   // ****************
   logic mclk;
   logic resetn;
   ref_radio_evt_s radio_evt;
   ref_bitcnt_s bit_cnt;
   logic [11:0] awaddr;
   logic awvalid;
   logic awready;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic wvalid;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready;
   logic [11:0] araddr;
   logic arvalid;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready;
   logic irq;
   logic rx_fast;
   int n_mismatch;
   int check_count;
   int cyc;
   ref_event_bank DUT (.mclk(mclk), .resetn(resetn), .radio_evt(radio_evt), .bit_cnt(bit_cnt),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq(irq), .rx_long_range_fast(rx_fast));
   // ****************
   // clock and timeout
   // ****************
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         conclude();
      end
   end
   // ****************
   // helpers
   // ****************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // bus handshakes are judged at the falling edge, where ready and valid are settled
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
      logic a_t;
      logic w_t;
      logic b_t;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_t = 1'b0;
      while (!b_t) begin
         @(negedge mclk);
         a_t = awvalid && awready;
         w_t = wvalid && wready;
         b_t = bvalid && bready;
         r = bresp;
         @(posedge mclk);
         if (a_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         if (b_t) bready <= 1'b0;
      end
   endtask
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic a_t;
      logic r_t;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_t = 1'b0;
      while (!r_t) begin
         @(negedge mclk);
         a_t = arvalid && arready;
         r_t = rvalid && rready;
         d = rdata;
         r = rresp;
         @(posedge mclk);
         if (a_t) arvalid <= 1'b0;
         if (r_t) rready <= 1'b0;
      end
   endtask
   task automatic wr_ok(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, 4'hF, r);
      chk(32'(r), 32'(RESP_OKAY));
   endtask
   task automatic rd_exp(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(32'(r), 32'(RESP_OKAY));
      chk(d, e);
   endtask
   task automatic pulse(input int k);
      @(posedge mclk);
      radio_evt <= ref_radio_evt_s'(12'h001 << k);
      @(posedge mclk);
      radio_evt <= '0;
   endtask
   task automatic tick();
      @(posedge mclk);
      bit_cnt.tick <= 1'b1;
      @(posedge mclk);
      bit_cnt.tick <= 1'b0;
   endtask
   // struct field k maps to event index k, skipping the bit match slot
   function automatic int evt_idx(input int k);
      return (k == 0) ? 0 : k + 1;
   endfunction
   // ****************
   // scenarios
   // ****************
   task automatic t_reset();
      for (int i = 0; i < NUM_EVT; i++) rd_exp(EVT_OFS[i], 32'h0000_0000);
      rd_exp(OFS_INT_STATUS, 32'h0000_0000);
      rd_exp(OFS_INT_MASK, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
      chk(32'(rx_fast), 32'h0000_0000);
      $display("test reset done");
   endtask
   task automatic t_events();
      int i;
      for (int k = 0; k < 12; k++) begin
         i = evt_idx(k);
         pulse(k);
         repeat (3) @(posedge mclk);
         rd_exp(EVT_OFS[i], 32'h0000_0001);
         rd_exp(OFS_INT_STATUS, 32'h0000_0001 << i);
         wr_ok(OFS_INT_STATUS, 32'h0000_0001 << i);
         rd_exp(EVT_OFS[i], 32'h0000_0001);
         wr_ok(EVT_OFS[i], 32'h0000_0000);
         rd_exp(EVT_OFS[i], 32'h0000_0000);
         pulse(k);
         rd_exp(EVT_OFS[i], 32'h0000_0001);
         wr_ok(EVT_OFS[i], 32'h0000_0000);
         wr_ok(OFS_INT_STATUS, 32'h0000_0001 << i);
      end
      wr_ok(OFS_RX_MODE, 32'h0000_0000);
      $display("test events done");
   endtask
   task automatic t_bitmatch();
      logic [1:0] r;
      wr_ok(OFS_BC_COMPARE, 32'h0000_0003);
      @(posedge mclk);
      bit_cnt.run <= 1'b1;
      tick();
      tick();
      rd_exp(EVT_OFS[IDX_BCM], 32'h0000_0000);
      tick();
      rd_exp(EVT_OFS[IDX_BCM], 32'h0000_0001);
      rd_exp(OFS_BC_COUNT, 32'h0000_0003);
      tick();
      rd_exp(OFS_BC_COUNT, 32'h0000_0004);
      @(posedge mclk);
      bit_cnt.run <= 1'b0;
      wr_ok(EVT_OFS[IDX_BCM], 32'h0000_0000);
      wr_ok(OFS_INT_STATUS, 32'h0000_0001 << IDX_BCM);
      rd_exp(EVT_OFS[IDX_BCM], 32'h0000_0000);
      // a strobe on lane 1 only keeps the low byte of the compare value
      axi_wr(OFS_BC_COMPARE, 32'h0000_5678, 4'h2, r);
      chk(32'(r), 32'(RESP_OKAY));
      rd_exp(OFS_BC_COMPARE, 32'h0000_5603);
      $display("test bit match done");
   endtask
   task automatic t_irq();
      pulse(1);
      repeat (2) @(negedge mclk);
      chk(32'(irq), 32'h0000_0000);
      wr_ok(OFS_INT_MASK, 32'h0000_0001 << IDX_CRC_GOOD);
      repeat (2) @(negedge mclk);
      chk(32'(irq), 32'h0000_0001);
      wr_ok(OFS_INT_STATUS, 32'h0000_0001 << IDX_CRC_GOOD);
      repeat (2) @(negedge mclk);
      chk(32'(irq), 32'h0000_0000);
      rd_exp(OFS_INT_STATUS, 32'h0000_0000);
      rd_exp(EVT_OFS[IDX_CRC_GOOD], 32'h0000_0001);
      pulse(2);
      repeat (2) @(negedge mclk);
      chk(32'(irq), 32'h0000_0000);
      wr_ok(OFS_INT_MASK, 32'h0000_0000);
      wr_ok(OFS_INT_STATUS, 32'h0000_1FFF);
      $display("test interrupt done");
   endtask
   task automatic t_rate();
      pulse(9);
      @(negedge mclk);
      chk(32'(rx_fast), 32'h0000_0001);
      rd_exp(OFS_RX_MODE, 32'h0000_0001);
      wr_ok(OFS_RX_MODE, 32'h0000_0000);
      rd_exp(OFS_RX_MODE, 32'h0000_0000);
      chk(32'(rx_fast), 32'h0000_0000);
      $display("test rate done");
   endtask
   task automatic t_refuse();
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(12'h300, 32'hFFFF_FFFF, 4'hF, r);
      chk(32'(r), 32'(RESP_SLVERR));
      axi_rd(12'h300, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      chk(d, 32'h0000_0000);
      axi_wr(OFS_BC_COUNT, 32'h0000_00FF, 4'hF, r);
      chk(32'(r), 32'(RESP_SLVERR));
      rd_exp(OFS_BC_COUNT, 32'h0000_0000);
      $display("test refusal done");
   endtask
   // ****************
   // main sequence
   // ****************
   initial begin
      mclk = 1'b0;
      n_mismatch = 0;
      check_count = 0;
      cyc = 0;
      resetn <= 1'b0;
      radio_evt <= '0;
      bit_cnt <= '0;
      awaddr <= 12'h000;
      awvalid <= 1'b0;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
      wvalid <= 1'b0;
      bready <= 1'b0;
      araddr <= 12'h000;
      arvalid <= 1'b0;
      rready <= 1'b0;
      repeat (16) @(posedge mclk);
      resetn <= 1'b1;
      t_reset();
      t_events();
      t_bitmatch();
      t_irq();
      t_rate();
      t_refuse();
      conclude();
   end
endmodule
